// File: verif/pfl_fault_logic_tb_top.sv
// Self-checking bench for the power switch fault logic.
`timescale 1ns/1ps
`include "pfl_map.vh"

module pfl_fault_logic_tb_top;
   reg        i_clk = 1'b0;
   reg        i_rst = 1'b1;
   reg  [7:0] i_addr = 8'h00;
   reg  [7:0] i_wdata = 8'h00;
   reg        i_wr = 1'b0, i_rd = 1'b0, i_on = 1'b0, i_bp_n = 1'b1, i_ov = 1'b0;
   reg        i_sl = 1'b0, i_oc = 1'b0, i_fb = 1'b0, i_cool = 1'b0, i_drv = 1'b1;
   reg        i_adc_v = 1'b0, host_en = 1'b0, host_slow = 1'b1;
   reg        i_ce = 1'b1, i_uv = 1'b0, i_sh = 1'b0;
   reg  [7:0] i_adc = 8'h00;
   reg  [7:0] rnd;
   wire [7:0] o_rdata;
   wire       o_gate_on, o_fast_off, o_pg_n, o_alert_n, o_resp, ara_won, addressed;
   int        err_total = 0;
   int        num_checks = 0;

   always #2.5 i_clk = ~i_clk;

   pfl_fault_logic #(.CB_CYC(50), .RETRY_CYC(50), .COOL_CYC(100)) i_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_on(i_on), .i_board_present_n(i_bp_n),
      .i_high_input_comparator(i_ov), .i_supply_high(i_sh), .i_low_input_comparator(i_uv),
      .i_supply_low(i_sl), .i_internal_supply_low(1'b0), .i_overcurrent_event(i_oc),
      .i_output_feedback_low(i_fb), .i_cooldown_done(i_cool), .i_gate_drive_ok(i_drv),
      .i_timer_strap(1'b0), .i_adc_valid(i_adc_v), .i_adc_sense(i_adc), .i_ara_won(ara_won),
      .i_addressed(addressed), .o_gate_on(o_gate_on), .o_fast_off(o_fast_off),
      .o_power_good_pin_oe_n(o_pg_n), .o_alert_pin_oe_n(o_alert_n), .o_ara_respond(o_resp));

   pfl_host_model i_host (.i_clk(i_clk), .i_rst(i_rst), .i_alert(o_alert_n), .i_respond(o_resp),
      .i_en(host_en), .i_slow(host_slow), .o_ara_won(ara_won), .o_addressed(addressed));

   function automatic logic [7:0] status_of(input logic ovp, input logic bp, input logic gate);
      status_of = {2'b00, gate, bp, 3'b000, ovp};
   endfunction

   function automatic logic cur(input int s);
      case (s)
         0: cur = o_gate_on;
         1: cur = o_pg_n;
         2: cur = o_fast_off;
         3: cur = o_alert_n;
         default: cur = o_resp;
      endcase
   endfunction

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, string nm);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(nm, e, o_rdata & m);
   endtask

   // Waits a bounded time for a level; running out ends the run.
   task automatic await(input int s, input logic e, input int lim, input string nm);
      int n;
      n = 0;
      while (cur(s) !== e && n < lim) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      chk(nm, {7'h00, e}, {7'h00, cur(s)});
      if (n >= lim) close_out();
   endtask

   task automatic hold(input int s, input logic e, input int cyc, input string nm);
      repeat (cyc) @(posedge i_clk);
      #1;
      chk(nm, {7'h00, e}, {7'h00, cur(s)});
   endtask

   initial begin
      void'($urandom(32'hf21a));
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(`PFL_ADDR_CTRL, {3'h0, `PFL_CTRL_RST}, 8'hff, "ctrl");
      rd(`PFL_ADDR_ALERT, 8'h00, 8'hff, "alert enables");
      rd(`PFL_ADDR_FAULT, 8'h00, 8'hff, "faults");
      rd(8'h10, 8'h00, 8'hff, "unmapped");
      hold(3, 1'b1, 1, "alert idle");
      $display("test reset done");
      @(posedge i_clk);
      i_on <= 1'b1;
      repeat (4) @(posedge i_clk);
      wr(`PFL_ADDR_CTRL, 8'h10);
      i_bp_n <= 1'b0;
      hold(0, 1'b0, 30, "gate before debounce");
      await(0, 1'b1, 700, "gate after insertion");
      rd(`PFL_ADDR_FAULT, 8'h10, 8'hff, "fault after insertion");
      rd(`PFL_ADDR_STATUS, status_of(1'b0, 1'b1, 1'b1), 8'hff, "status");
      $display("test insertion done");
      wr(`PFL_ADDR_ALERT, 8'h10);
      hold(3, 1'b0, 6, "alert pulled");
      hold(4, 1'b1, 0, "response owed");
      host_en <= 1'b1;
      await(3, 1'b1, 100, "alert released");
      hold(3, 1'b1, 60, "alert stays released");
      host_slow <= 1'b0;
      wr(`PFL_ADDR_FAULT, 8'h50);
      hold(3, 1'b0, 20, "pin bit pull");
      hold(4, 1'b0, 0, "no response owed");
      wr(`PFL_ADDR_FAULT, 8'h10);
      await(3, 1'b1, 10, "pin bit off");
      for (int i = 0; i < 4; i++) begin
         rnd = $urandom;
         wr(`PFL_ADDR_ALERT, rnd);
         rd(`PFL_ADDR_ALERT, {2'b00, rnd[5:0]}, 8'hff, "alert enables");
      end
      wr(`PFL_ADDR_ALERT, 8'h00);
      $display("test alert done");
      wr(`PFL_ADDR_CTRL, 8'h19);
      i_ov <= 1'b1;
      hold(0, 1'b1, 300, "gate in filter");
      await(0, 1'b0, 150, "gate on overvoltage");
      rd(`PFL_ADDR_STATUS, status_of(1'b1, 1'b1, 1'b0), 8'hff, "ov status");
      rd(`PFL_ADDR_FAULT, 8'h11, 8'hff, "ov fault");
      i_ov <= 1'b0;
      await(0, 1'b1, 400, "gate after retry");
      wr(`PFL_ADDR_FAULT, 8'h04);
      await(0, 1'b0, 10, "host fault latch");
      wr(`PFL_ADDR_FAULT, 8'h00);
      await(0, 1'b1, 10, "host fault clear");
      wr(`PFL_ADDR_CTRL, 8'h1b);
      i_uv <= 1'b1;
      await(0, 1'b0, 420, "gate on undervoltage");
      rd(`PFL_ADDR_STATUS, 8'h02, 8'h02, "uv present");
      i_uv <= 1'b0;
      await(0, 1'b1, 400, "gate after uv retry");
      i_sh <= 1'b1;
      await(0, 1'b0, 420, "gate on supply high");
      i_sh <= 1'b0;
      await(0, 1'b1, 400, "gate after ov retry");
      $display("test voltage done");
      i_oc <= 1'b1;
      hold(0, 1'b1, 30, "gate in breaker time");
      await(0, 1'b0, 60, "gate on breaker");
      i_oc <= 1'b0;
      rd(`PFL_ADDR_FAULT, 8'h04, 8'h04, "oc fault");
      wr(`PFL_ADDR_FAULT, 8'h00);
      hold(0, 1'b0, 20, "gate before cool-down");
      i_cool <= 1'b1;
      await(0, 1'b1, 20, "gate after cool-down");
      $display("test overcurrent done");
      i_ce <= 1'b0;
      wr(`PFL_ADDR_CTRL, 8'h10);
      hold(0, 1'b1, 10, "gate frozen");
      i_ce <= 1'b1;
      rd(`PFL_ADDR_CTRL, 8'h08, 8'h08, "switch kept");
      $display("test clock enable done");
      i_drv <= 1'b0;
      i_fb <= 1'b1;
      hold(1, 1'b1, 450, "no power bad on weak drive");
      i_drv <= 1'b1;
      await(1, 1'b0, 420, "power bad pin");
      rd(`PFL_ADDR_STATUS, 8'h08, 8'h08, "power bad present");
      i_fb <= 1'b0;
      await(1, 1'b1, 20, "power good again");
      i_on <= 1'b0;
      await(0, 1'b0, 10, "gate on input low");
      i_on <= 1'b1;
      await(0, 1'b1, 20, "gate on input high");
      i_bp_n <= 1'b1;
      await(0, 1'b0, 8, "gate on removal");
      rd(`PFL_ADDR_STATUS, 8'h00, 8'h10, "board present");
      rd(`PFL_ADDR_FAULT, 8'h10, 8'h10, "board changed");
      $display("test turn-off done");
      @(posedge i_clk);
      i_adc <= `PFL_SHORT_CODE;
      i_adc_v <= 1'b1;
      @(posedge i_clk);
      i_adc_v <= 1'b0;
      rd(`PFL_ADDR_FAULT, 8'h20, 8'h20, "switch short");
      i_sl <= 1'b1;
      await(2, 1'b1, 420, "fast shutdown");
      i_sl <= 1'b0;
      $display("test short and supply done");
      close_out();
   end
endmodule // pfl_fault_logic_tb_top

bind pfl_fault_logic pfl_fault_props i_props (.i_clk(i_clk), .i_rst(i_rst), .i_rd(i_rd),
   .o_rdata(o_rdata), .i_on(i_on), .i_board_present_n(i_board_present_n),
   .i_high_input_comparator(i_high_input_comparator), .i_supply_low(i_supply_low),
   .i_internal_supply_low(i_internal_supply_low), .i_output_feedback_low(i_output_feedback_low),
   .i_ara_won(i_ara_won), .i_addressed(i_addressed), .o_gate_on(o_gate_on),
   .o_fast_off(o_fast_off), .o_power_good_pin_oe_n(o_power_good_pin_oe_n),
   .o_alert_pin_oe_n(o_alert_pin_oe_n), .o_ara_respond(o_ara_respond));

// File: verif/pfl_fault_props.sv
// Concurrent checks on the ports of the power switch fault logic.
`timescale 1ns/1ps

module pfl_fault_props (
   input wire       i_clk,
   input wire       i_rst,
   input wire       i_rd,
   input wire [7:0] o_rdata,
   input wire       i_on,
   input wire       i_board_present_n,
   input wire       i_high_input_comparator,
   input wire       i_supply_low,
   input wire       i_internal_supply_low,
   input wire       i_output_feedback_low,
   input wire       i_ara_won,
   input wire       i_addressed,
   input wire       o_gate_on,
   input wire       o_fast_off,
   input wire       o_power_good_pin_oe_n,
   input wire       o_alert_pin_oe_n,
   input wire       o_ara_respond
);
   reg [9:0] ov_cnt;
   reg [9:0] sl_cnt;

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);

   // Counts how long the raw high input comparator and supply low inputs have been held, saturating.
   always @(posedge i_clk) begin
      if (i_rst || !i_high_input_comparator) ov_cnt <= 10'h000;
      else if (ov_cnt != 10'h3ff) ov_cnt <= ov_cnt + 10'h001;
      if (i_rst || !i_supply_low) sl_cnt <= 10'h000;
      else if (sl_cnt != 10'h3ff) sl_cnt <= sl_cnt + 10'h001;
   end

   reset_state_a: assert property ($fell(i_rst) |-> !o_gate_on && o_alert_pin_oe_n && !o_ara_respond)
      else $error("outputs not idle after reset");
   rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
      else $error("read data outside its cycle");
   on_low_off_a: assert property ($fell(i_on) |-> ##[1:8] !o_gate_on)
      else $error("gate stayed on after on input fell");
   removal_off_a: assert property ($rose(i_board_present_n) |-> ##[1:8] !o_gate_on)
      else $error("gate stayed on after board removal");
   ov_filter_a: assert property (ov_cnt == 10'h19a |-> !o_gate_on)
      else $error("gate on during held overvoltage");
   supply_fast_a: assert property (sl_cnt == 10'h19a |-> o_fast_off)
      else $error("no fast shutdown on low supply");
   fast_cause_a: assert property ($rose(o_fast_off) |->
      $past(i_supply_low, 4) || $past(i_internal_supply_low, 4))
      else $error("fast shutdown without supply fault");
   ara_release_a: assert property (i_ara_won && o_ara_respond |-> ##[1:2] !o_ara_respond)
      else $error("alert response did not release");
   addr_release_a: assert property (i_addressed |-> ##[1:2] !o_ara_respond)
      else $error("direct address did not release");
   pg_gate_a: assert property ($fell(o_power_good_pin_oe_n) |->
      $past(o_gate_on) && $past(i_output_feedback_low, 4))
      else $error("power bad without gate on");

   cover property (o_gate_on ##1 !o_gate_on);
   cover property (i_ara_won && o_ara_respond);
   cover property (!o_power_good_pin_oe_n);
endmodule // pfl_fault_props

// File: verif/pfl_host_model.sv
// Bus host model that answers a pulled alert line.
`timescale 1ns/1ps

module pfl_host_model (
   input  wire i_clk,
   input  wire i_rst,
   input  wire i_alert,
   input  wire i_respond,
   input  wire i_en,
   input  wire i_slow,
   output reg  o_ara_won,
   output reg  o_addressed
);
   reg [7:0] wait_cnt;

   // Broadcasts the response address if the device owes an alert, else polls it directly.
   always @(posedge i_clk) begin
      o_ara_won <= 1'b0;
      o_addressed <= 1'b0;
      if (i_rst || i_alert || !i_en) begin
         wait_cnt <= 8'h00;
      end else if (wait_cnt == (i_slow ? 8'h30 : 8'h04)) begin
         wait_cnt <= 8'h00;
         if (i_respond) o_ara_won <= 1'b1;
         else o_addressed <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 8'h01;
      end
   end
endmodule // pfl_host_model

// File: verilog/pfl_fault_logic.v
// Fault supervision, gate decision and alert pin logic of the power switch.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
`include "pfl_map.vh"

module pfl_fault_logic #(
   parameter integer CB_CYC    = `PFL_CB_CYC,
   parameter integer RETRY_CYC = `PFL_RETRY_CYC,
   parameter integer COOL_CYC  = `PFL_COOL_CYC,
   parameter [7:0]   SHORT_CODE = `PFL_SHORT_CODE
) (
   input  wire       i_clk,
   input  wire       i_rst,
   input  wire       i_ce,
   input  wire [7:0] i_addr,
   input  wire [7:0] i_wdata,
   input  wire       i_wr,
   input  wire       i_rd,
   output reg  [7:0] o_rdata,
   input  wire       i_on,
   input  wire       i_board_present_n,
   input  wire       i_high_input_comparator,
   input  wire       i_supply_high,
   input  wire       i_low_input_comparator,
   input  wire       i_supply_low,
   input  wire       i_internal_supply_low,
   input  wire       i_overcurrent_event,
   input  wire       i_output_feedback_low,
   input  wire       i_cooldown_done,
   input  wire       i_gate_drive_ok,
   input  wire       i_timer_strap,
   input  wire       i_adc_valid,
   input  wire [7:0] i_adc_sense,
   input  wire       i_ara_won,
   input  wire       i_addressed,
   output reg        o_gate_on,
   output reg        o_fast_off,
   output reg        o_power_good_pin_oe_n,
   output reg        o_alert_pin_oe_n,
   output reg        o_ara_respond
);

   localparam integer NS = 11;
   localparam integer NQ = 10;

   // Qualification length of each filtered condition.
   function [31:0] qlim;
      input integer k;
      begin
         case (k)
            3:       qlim = `PFL_ISUP_CYC;
            5:       qlim = CB_CYC;
            6, 7, 8: qlim = RETRY_CYC;
            9:       qlim = COOL_CYC;
            default: qlim = `PFL_FILT_CYC;
         endcase
      end
   endfunction

   wire [NS-1:0] raw_in;
   reg  [NS-1:0] sync1;
   reg  [NS-1:0] sync2;
   reg  [NS-1:0] sync3;
   wire [NQ-1:0] qcond;
   wire [NQ-1:0] qual;
   reg  [NQ-1:0] qual_d;
   wire [NQ-1:0] qrise;

   reg  [2:0] retry;
   reg        switch_on;
   reg        pg_cfg;
   reg  [5:0] alert_en;
   reg  [5:0] faults;
   reg        alert_pin_output_bit;
   reg  [5:0] pending;
   reg        overvoltage_present_flag;
   reg        undervoltage_present_flag;
   reg        power_bad_present_flag;
   reg        board_present_flag;
   reg        ov_hold;
   reg        uv_hold;
   reg        oc_wait;
   reg        strap;
   reg  [1:0] por_cnt;

   reg  [5:0] next_faults;
   reg  [5:0] next_pending;
   reg        next_switch_on;
   reg        next_gate;

   assign raw_in = {i_gate_drive_ok, i_cooldown_done, i_output_feedback_low,
                    i_overcurrent_event, i_internal_supply_low, i_supply_low,
                    i_low_input_comparator, i_supply_high, i_high_input_comparator,
                    i_board_present_n, i_on};

   wire s_on     = sync2[0];
   wire s_pres_n = sync2[1];
   wire s_ov     = sync2[2] | sync2[3];
   wire s_uv     = sync2[4];
   wire s_fb_low = sync2[8];
   wire s_cool   = sync2[9];
   wire por_chk  = (por_cnt == 2'h1);
   // Edges count only once the third stage holds a real sample, so reset fakes none.
   wire edge_ok  = (por_cnt == 2'h0);
   wire on_rise  = edge_ok & sync2[0] & ~sync3[0];
   wire on_fall  = edge_ok & ~sync2[0] & sync3[0];
   wire pres_chg = edge_ok & (sync2[1] ^ sync3[1]);
   wire insert   = edge_ok & ~sync2[1] & sync3[1];

   // Two-stage synchronisers; a third stage feeds the edge detectors.
   always @(posedge i_clk) begin
      if (i_rst) begin
         sync1 <= {NS{1'b0}};
         sync2 <= {NS{1'b0}};
         sync3 <= {NS{1'b0}};
      end else if (i_ce) begin
         sync1 <= raw_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   assign qcond[0] = s_ov;
   assign qcond[1] = s_uv;
   assign qcond[2] = sync2[5];
   assign qcond[3] = sync2[6];
   assign qcond[4] = s_fb_low & o_gate_on & sync2[10];
   assign qcond[5] = sync2[7] & o_gate_on;
   assign qcond[6] = ~s_ov;
   assign qcond[7] = ~s_uv;
   assign qcond[8] = ~s_pres_n;
   assign qcond[9] = oc_wait & strap;

   // Each qualifier counts while its condition holds and restarts when it drops.
   genvar g;
   generate
      for (g = 0; g < NQ; g = g + 1) begin : g_qual
         reg [31:0] cnt;
         reg        hit;
         always @(posedge i_clk) begin
            if (i_rst) begin
               cnt <= 32'h0;
               hit <= 1'b0;
            end else if (i_ce) begin
               if (!qcond[g]) begin
                  cnt <= 32'h0;
                  hit <= 1'b0;
               end else if (cnt >= qlim(g)) begin
                  hit <= 1'b1;
               end else begin
                  cnt <= cnt + 32'h1;
               end
            end
         end
         assign qual[g] = hit;
      end
   endgenerate

   assign qrise = qual & ~qual_d;

   wire wr_ctrl  = i_wr & (i_addr == `PFL_ADDR_CTRL);
   wire wr_alert = i_wr & (i_addr == `PFL_ADDR_ALERT);
   wire wr_fault = i_wr & (i_addr == `PFL_ADDR_FAULT);

   wire [5:0] present_mask = {2'b00, power_bad_present_flag, 1'b0,
                              undervoltage_present_flag, overvoltage_present_flag};
   wire       short_seen   = i_adc_valid & ~o_gate_on & (i_adc_sense >= SHORT_CODE);
   wire       alert_clr    = (i_ara_won & o_ara_respond) | i_addressed;
   wire [5:0] fault_set;

   assign fault_set[0] = qrise[0];
   assign fault_set[1] = qrise[1] | (por_chk & s_uv);
   assign fault_set[2] = qrise[5];
   assign fault_set[3] = qrise[4];
   assign fault_set[4] = pres_chg;
   assign fault_set[5] = short_seen;

   always @* begin
      next_faults = faults;
      if (wr_fault)
         next_faults = i_wdata[5:0] | (faults & present_mask);
      if (insert)
         next_faults = next_faults & (6'h10 | present_mask);
      next_faults = next_faults | fault_set;
   end

   // An alert is owed once per fresh rising of a fault bit.
   always @* begin
      next_pending = pending & next_faults;
      if (alert_clr)
         next_pending = 6'h00;
      next_pending = next_pending | (next_faults & ~faults);
   end

   always @* begin
      next_switch_on = switch_on;
      if (wr_ctrl)
         next_switch_on = i_wdata[`PFL_CTRL_SWON];
      if (on_rise)
         next_switch_on = 1'b1;
      if (on_fall)
         next_switch_on = 1'b0;
      if (qrise[8])
         next_switch_on = s_on;
   end

   always @* begin
      next_gate = next_switch_on & board_present_flag & ~s_pres_n;
      if (ov_hold | uv_hold | oc_wait)
         next_gate = 1'b0;
      if (qual[0] | qual[1] | qual[2] | qual[3] | qual[5])
         next_gate = 1'b0;
      if (|(faults[2:0] & ~retry))
         next_gate = 1'b0;
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         retry     <= 3'h0;
         switch_on <= 1'b0;
         pg_cfg    <= 1'b1;
         alert_en  <= `PFL_ALERT_RST;
         alert_pin_output_bit <= 1'b0;
      end else if (i_ce) begin
         switch_on <= next_switch_on;
         if (wr_ctrl) begin
            retry  <= i_wdata[2:0];
            pg_cfg <= i_wdata[`PFL_CTRL_PGCFG];
         end
         if (wr_alert)
            alert_en <= i_wdata[5:0];
         if (wr_fault)
            alert_pin_output_bit <= i_wdata[`PFL_FAULT_PINOUT];
      end
   end

   // Strap is sampled once, after the synchronisers have filled.
   always @(posedge i_clk) begin
      if (i_rst) begin
         por_cnt <= 2'h3;
         strap   <= 1'b0;
      end else if (i_ce) begin
         if (por_cnt != 2'h0)
            por_cnt <= por_cnt - 2'h1;
         if (por_chk)
            strap <= i_timer_strap;
      end
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         qual_d  <= {NQ{1'b0}};
         faults  <= 6'h00;
         pending <= 6'h00;
         overvoltage_present_flag  <= 1'b0;
         undervoltage_present_flag <= 1'b0;
         power_bad_present_flag    <= 1'b0;
         board_present_flag        <= 1'b0;
         ov_hold <= 1'b0;
         uv_hold <= 1'b0;
         oc_wait <= 1'b0;
      end else if (i_ce) begin
         qual_d  <= qual;
         faults  <= next_faults;
         pending <= next_pending;
         if (qual[0])
            overvoltage_present_flag <= 1'b1;
         else if (!s_ov)
            overvoltage_present_flag <= 1'b0;
         if (qual[1])
            undervoltage_present_flag <= 1'b1;
         else if (!s_uv)
            undervoltage_present_flag <= 1'b0;
         if (qual[4])
            power_bad_present_flag <= 1'b1;
         else if (!s_fb_low)
            power_bad_present_flag <= 1'b0;
         if (insert)
            board_present_flag <= 1'b1;
         else if (s_pres_n)
            board_present_flag <= 1'b0;
         // A hold ends after the quiet time; with retry off the latched fault
         // keeps the gate off until software or a board insertion clears it, so the switch never
         // stays stuck off once the condition and the fault are gone and any overcurrent cool-down (oc_wait) has ended.
         if (qual[0])
            ov_hold <= 1'b1;
         else if (qual[6])
            ov_hold <= 1'b0;
         if (qual[1])
            uv_hold <= 1'b1;
         else if (qual[7])
            uv_hold <= 1'b0;
         if (qrise[5])
            oc_wait <= 1'b1;
         else if (strap ? qual[9] : s_cool)
            oc_wait <= 1'b0;
      end
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         o_gate_on  <= 1'b0;
         o_fast_off <= 1'b0;
         o_power_good_pin_oe_n <= 1'b1;
         o_alert_pin_oe_n      <= 1'b1;
         o_ara_respond         <= 1'b0;
      end else if (i_ce) begin
         o_gate_on  <= next_gate;
         o_fast_off <= qual[2] | qual[3];
         o_power_good_pin_oe_n <= ~(pg_cfg & (power_bad_present_flag | qual[4]));
         o_alert_pin_oe_n <= ~(|(next_pending & alert_en) | alert_pin_output_bit);
         o_ara_respond    <= |(next_pending & alert_en);
      end
   end

   // Read data stand only in the cycle after the strobe.
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else if (i_ce) begin
         o_rdata <= 8'h00;
         if (i_rd) begin
            case (i_addr)
               `PFL_ADDR_CTRL:
                  o_rdata <= {3'b000, pg_cfg, switch_on, retry};
               `PFL_ADDR_ALERT:
                  o_rdata <= {2'b00, alert_en};
               `PFL_ADDR_STATUS:
                  o_rdata <= {2'b00, o_gate_on, board_present_flag,
                              power_bad_present_flag, 1'b0,
                              undervoltage_present_flag, overvoltage_present_flag};
               `PFL_ADDR_FAULT:
                  o_rdata <= {1'b0, alert_pin_output_bit, faults};
               default:
                  o_rdata <= 8'h00;
            endcase
         end
      end
   end

endmodule // pfl_fault_logic

// File: verilog/pfl_map.vh
// Constants for the power switch fault logic: offsets, fields, resets and timing.
`ifndef PFL_MAP_VH
`define PFL_MAP_VH

`define PFL_CLK_MHZ          200
`define PFL_ADDR_CTRL        8'h00
`define PFL_ADDR_ALERT       8'h04
`define PFL_ADDR_STATUS      8'h08
`define PFL_ADDR_FAULT       8'h0c

`define PFL_CTRL_RST         5'h10
`define PFL_ALERT_RST        6'h00
`define PFL_FAULT_RST        7'h00

`define PFL_CTRL_SWON        3
`define PFL_CTRL_PGCFG       4
`define PFL_FAULT_PINOUT     6

`define PFL_FILT_US          2
`define PFL_ISUP_US          1
`define PFL_CB_US            20
`define PFL_RETRY_MS         100
`define PFL_COOL_S           5
`define PFL_FILT_CYC         (`PFL_FILT_US * `PFL_CLK_MHZ)
`define PFL_ISUP_CYC         (`PFL_ISUP_US * `PFL_CLK_MHZ)
`define PFL_CB_CYC           (`PFL_CB_US * `PFL_CLK_MHZ)
`define PFL_RETRY_CYC        (`PFL_RETRY_MS * 1000 * `PFL_CLK_MHZ)
`define PFL_COOL_CYC         (`PFL_COOL_S * 1000000 * `PFL_CLK_MHZ)
`define PFL_SHORT_CODE       8'h0b

`endif
